// *** verilog/np_rx_pkg.sv ***
package np_rx_pkg;
  // Widths
  localparam int ADDR_W = 10;
  localparam int DATA_W = 16;
  localparam int CNT_W = 2;
  // Register offsets
  localparam logic [ADDR_W-1:0] PARTNER_NP_OFS = 10'h0de;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 10'h1f0;
  // Link code word field positions
  localparam int MORE_PAGES_BIT = 15;
  localparam int ACK_BIT = 14;
  localparam int MSG_PAGE_BIT = 13;
  localparam int COMPLY_BIT = 12;
  localparam int TOGGLE_BIT = 11;
  localparam int CODE_HI = 10;
  localparam int CODE_LO = 0;
  // Control register fields
  localparam int CTRL_CAPTURE_EN_BIT = 0;
  localparam int CTRL_TOGGLE_CLR_BIT = 1;
  localparam int STAT_TOGGLE_ERR_BIT = 8;
  // Reset values
  localparam logic [DATA_W-1:0] PARTNER_NP_RST = 16'h0000;
  localparam logic CTRL_CAPTURE_RST = 1'b1;
  // Matching bursts needed before acknowledge
  localparam logic [CNT_W-1:0] CONSIST_BURSTS = 2'h3;

  // Word with acknowledge bit masked out for comparison
  function automatic logic [DATA_W-1:0] no_ack(input logic [DATA_W-1:0] w);
    logic [DATA_W-1:0] r;
    r = w;
    r[ACK_BIT] = 1'b0;
    return r;
  endfunction
endpackage

// *** verilog/np_burst_match.sv ***
module np_burst_match
  import np_rx_pkg::*;
(
  // Clock, reset, enable
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  // Received bursts
  input wire logic i_burst_valid,
  input wire logic [np_rx_pkg::DATA_W-1:0] i_burst_word,
  // Match state
  output logic [np_rx_pkg::CNT_W-1:0] o_match_cnt,
  output logic o_stable_pulse
);
  import np_rx_pkg::*;

  logic [DATA_W-1:0] last_q, last_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic pulse_q, pulse_d;

  ////////////////////////////////////////////////////////////////////////////
  // Count consecutive consistent bursts, acknowledge bit ignored
  always_comb begin
    last_d = last_q;
    cnt_d = cnt_q;
    pulse_d = 1'b0;
    if (i_burst_valid) begin
      last_d = i_burst_word;
      if (cnt_q != '0 && no_ack(i_burst_word) == no_ack(last_q)) begin
        if (cnt_q != CONSIST_BURSTS) begin
          cnt_d = cnt_q + 2'h1;
          pulse_d = (cnt_q + 2'h1) == CONSIST_BURSTS;
        end
      end else begin
        cnt_d = 2'h1;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      last_q <= '0;
      cnt_q <= '0;
      pulse_q <= 1'b0;
    end else if (i_ce) begin
      last_q <= last_d;
      cnt_q <= cnt_d;
      pulse_q <= pulse_d;
    end
  end

  assign o_match_cnt = cnt_q;
  assign o_stable_pulse = pulse_q;
endmodule // np_burst_match

// *** verilog/partner_next_page_status.sv ***
// Contract
// - Bit 15 reports received more-pages flag; one means more pages follow.
// - Acknowledge sits in bit 14 regardless of selector or encoding.
// - Acknowledge set only after three consecutive matching bursts, ack ignored.
// - Bit 13 reports message page (one) or unformatted page (zero).
// - Bit 12 reports partner's can-comply flag.
// - Can-comply reads one when partner complies, zero otherwise.
// - Bit 11 toggle must invert previous word's toggle; mismatch is flagged.
// - Bits 10 to 0 hold the read-only 11-bit code field.
//
// The implementer's own choice: strobed register access.
module partner_next_page_status
  import np_rx_pkg::*;
(
  // Clock, reset, enable
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  // Register port
  input wire logic [np_rx_pkg::ADDR_W-1:0] i_addr,
  input wire logic [np_rx_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [np_rx_pkg::DATA_W-1:0] o_rdata,
  // Link side
  input wire logic i_burst_valid,
  input wire logic [np_rx_pkg::DATA_W-1:0] i_burst_word,
  input wire logic i_np_pending,
  output logic o_ack_tx,
  output logic o_page_stored,
  output logic o_toggle_err
);
  import np_rx_pkg::*;

  logic [CNT_W-1:0] match_cnt;
  logic stable_pulse;
  logic [DATA_W-1:0] stable_word_q, stable_word_d;
  logic [DATA_W-1:0] page_q, page_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic have_prev_q, have_prev_d;
  logic prev_tgl_q, prev_tgl_d;
  logic tgl_err_q, tgl_err_d;
  logic capture_en_q, capture_en_d;
  logic ack_q, ack_d;
  logic stored_q, stored_d;
  logic store;
  logic tgl_bad;

  np_burst_match u_match (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .i_burst_valid(i_burst_valid),
    .i_burst_word(i_burst_word),
    .o_match_cnt(match_cnt),
    .o_stable_pulse(stable_pulse)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Page capture and toggle tracking
  always_comb begin
    stable_word_d = i_burst_valid ? i_burst_word : stable_word_q;
    tgl_bad = have_prev_q && (stable_word_q[TOGGLE_BIT] == prev_tgl_q);
    store = stable_pulse && capture_en_q && !tgl_bad;
    page_d = page_q;
    have_prev_d = have_prev_q;
    prev_tgl_d = prev_tgl_q;
    tgl_err_d = tgl_err_q;
    if (i_wr && i_addr == CTRL_OFS && i_wdata[CTRL_TOGGLE_CLR_BIT]) begin
      tgl_err_d = 1'b0;
    end
    if (stable_pulse && capture_en_q && tgl_bad) begin
      tgl_err_d = 1'b1;
    end
    if (store) begin
      page_d = stable_word_q;
      have_prev_d = 1'b1;
      prev_tgl_d = stable_word_q[TOGGLE_BIT];
    end
    stored_d = store;
    ack_d = (match_cnt == CONSIST_BURSTS) && !i_np_pending;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port, partner page is read-only
  always_comb begin
    capture_en_d = capture_en_q;
    rdata_d = '0;
    if (i_wr && i_addr == CTRL_OFS) begin
      capture_en_d = i_wdata[CTRL_CAPTURE_EN_BIT];
    end
    if (i_rd) begin
      case (i_addr)
        PARTNER_NP_OFS: rdata_d = page_q;
        CTRL_OFS: begin
          rdata_d[CTRL_CAPTURE_EN_BIT] = capture_en_q;
          rdata_d[STAT_TOGGLE_ERR_BIT] = tgl_err_q;
        end
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      stable_word_q <= '0;
      page_q <= PARTNER_NP_RST;
      rdata_q <= '0;
      have_prev_q <= 1'b0;
      prev_tgl_q <= 1'b0;
      tgl_err_q <= 1'b0;
      capture_en_q <= CTRL_CAPTURE_RST;
      ack_q <= 1'b0;
      stored_q <= 1'b0;
    end else if (i_ce) begin
      stable_word_q <= stable_word_d;
      page_q <= page_d;
      rdata_q <= rdata_d;
      have_prev_q <= have_prev_d;
      prev_tgl_q <= prev_tgl_d;
      tgl_err_q <= tgl_err_d;
      capture_en_q <= capture_en_d;
      ack_q <= ack_d;
      stored_q <= stored_d;
    end
  end

  assign o_rdata = rdata_q;
  assign o_ack_tx = ack_q;
  assign o_page_stored = stored_q;
  assign o_toggle_err = tgl_err_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_store;
    i_ce && store;
  endsequence

  sequence s_bad_toggle;
    i_ce && stable_pulse && capture_en_q && tgl_bad;
  endsequence

  sequence s_page_read;
    i_ce && i_rd && i_addr == PARTNER_NP_OFS;
  endsequence

  sequence s_ctrl_read;
    i_ce && i_rd && i_addr == CTRL_OFS;
  endsequence

  sequence s_err_clear;
    i_ce && i_wr && i_addr == CTRL_OFS && i_wdata[CTRL_TOGGLE_CLR_BIT] &&
      !(stable_pulse && capture_en_q && tgl_bad);
  endsequence

  a_more_pages_bit: assert property (
    s_store |=> page_q[MORE_PAGES_BIT] == $past(stable_word_q[MORE_PAGES_BIT]) &&
      o_page_stored)
    else $error("more-pages bit not captured");
  a_ack_bit_pos: assert property (
    s_store |=> page_q[ACK_BIT] == $past(stable_word_q[ACK_BIT]))
    else $error("ack bit misplaced");
  a_msg_page_bit: assert property (
    s_store |=> page_q[MSG_PAGE_BIT] == $past(stable_word_q[MSG_PAGE_BIT]))
    else $error("message page bit wrong");
  a_comply_bit: assert property (
    s_store |=> page_q[COMPLY_BIT] == $past(stable_word_q[COMPLY_BIT]))
    else $error("comply bit wrong");
  a_code_field: assert property (
    s_store |=> page_q[CODE_HI:CODE_LO] == $past(stable_word_q[CODE_HI:CODE_LO]))
    else $error("code field wrong");
  a_stored_pulse: assert property (
    i_ce && o_page_stored |=> !o_page_stored)
    else $error("stored pulse too long");
  a_no_capture: assert property (
    i_ce && stable_pulse && !capture_en_q |=> $stable(page_q) && !o_page_stored)
    else $error("page stored while capture off");

  a_ack_after_three: assert property (
    i_ce && $rose(o_ack_tx) |-> $past(match_cnt) == CONSIST_BURSTS && !$past(i_np_pending))
    else $error("ack without three matches");
  a_ack_level: assert property (
    i_ce && match_cnt == CONSIST_BURSTS && !i_np_pending |=> o_ack_tx)
    else $error("ack missing after three matches");
  a_ack_pending: assert property (
    i_ce && i_np_pending |=> !o_ack_tx)
    else $error("ack while page pending");

  a_comply_reads: assert property (
    s_page_read |=> o_rdata[COMPLY_BIT] == $past(page_q[COMPLY_BIT]))
    else $error("comply readback wrong");
  a_page_reads: assert property (
    s_page_read |=> o_rdata == $past(page_q))
    else $error("page readback wrong");
  a_ctrl_read: assert property (
    s_ctrl_read |=> o_rdata[STAT_TOGGLE_ERR_BIT] == $past(tgl_err_q) &&
      o_rdata[CTRL_CAPTURE_EN_BIT] == $past(capture_en_q))
    else $error("control readback wrong");
  a_unmapped_read: assert property (
    i_ce && i_rd && i_addr != PARTNER_NP_OFS && i_addr != CTRL_OFS |=> o_rdata == '0)
    else $error("unmapped read not zero");
  a_rdata_idle: assert property (
    i_ce && !i_rd |=> o_rdata == '0)
    else $error("read data without read");

  a_toggle_reject: assert property (
    s_bad_toggle |=> o_toggle_err && $stable(page_q) && !o_page_stored)
    else $error("toggle repeat accepted");
  a_toggle_clear: assert property (
    s_err_clear |=> !o_toggle_err)
    else $error("toggle error not cleared");
  a_err_sticky: assert property (
    o_toggle_err && !(i_ce && i_wr && i_addr == CTRL_OFS && i_wdata[CTRL_TOGGLE_CLR_BIT]) |=>
      o_toggle_err)
    else $error("toggle error dropped");

  a_write_ignored: assert property (
    i_wr && !store |=> $stable(page_q))
    else $error("host write changed page");
  a_reset_zero: assert property (
    $rose(i_nrst) |-> page_q == PARTNER_NP_RST && !o_ack_tx && !o_toggle_err &&
      capture_en_q == CTRL_CAPTURE_RST)
    else $error("state not cleared by reset");
  a_ce_freeze: assert property (
    !i_ce |=> $stable(page_q) && $stable(o_rdata) && $stable(o_ack_tx) &&
      $stable(o_toggle_err) && $stable(o_page_stored))
    else $error("state moved while enable low");
endmodule // partner_next_page_status

// *** bench/np_link_partner.sv ***
module np_link_partner
  import np_rx_pkg::*;
(
  // Clock and request
  input wire logic i_ref_clk,
  input wire logic i_go,
  input wire logic [np_rx_pkg::DATA_W-1:0] i_word,
  input wire logic [2:0] i_n,
  // Bursts
  output logic o_burst_valid,
  output logic [np_rx_pkg::DATA_W-1:0] o_burst_word
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] left_q = 4'h0;
  logic [DATA_W-1:0] word_q = 16'h0000;
  // Bursts two cycles apart, word line scrambled when idle
  always_ff @(posedge i_ref_clk) begin
    if (i_go) begin
      left_q <= {i_n, 1'b0};
      word_q <= i_word;
    end else if (left_q != 4'h0) begin
      left_q <= left_q - 4'h1;
      if (left_q == 4'h1) word_q <= ~word_q;
    end
  end
  assign o_burst_valid = left_q[0];
  assign o_burst_word = word_q;
endmodule // np_link_partner

// *** bench/partner_next_page_status_bench.sv ***
module partner_next_page_status_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import np_rx_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, rd = 1'b0, wr = 1'b0, pend = 1'b0, go = 1'b0;
  logic ce = 1'b1;
  logic [ADDR_W-1:0] addr = 10'h000;
  logic [DATA_W-1:0] wdata = 16'h0000, pw = 16'h0000, rdata, bword, w;
  logic [2:0] pn = 3'h0;
  logic bvalid, ack, stored, terr, got, tog;
  int n_fail = 0, comparisons = 0, cycles = 0;
  always #20 clk = ~clk;
  partner_next_page_status dut_u (.i_ref_clk(clk), .i_nrst(nrst), .i_ce(ce), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_burst_valid(bvalid),
    .i_burst_word(bword), .i_np_pending(pend), .o_ack_tx(ack), .o_page_stored(stored),
    .o_toggle_err(terr));
  np_link_partner lp_u (.i_ref_clk(clk), .i_go(go), .i_word(pw), .i_n(pn),
    .o_burst_valid(bvalid), .o_burst_word(bword));
  //////////////////////////////////////////////////////////////////
  task results();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      results();
    end
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task rdx(input logic [9:0] a, input logic [15:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task wrx(input logic [9:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task send(input logic [15:0] v, input int n);
    int k;
    got = 1'b0;
    @(posedge clk);
    go <= 1'b1;
    pw <= v;
    pn <= n[2:0];
    @(posedge clk);
    go <= 1'b0;
    for (k = 0; k < 2 * n + 6 && !got; k++) begin
      @(posedge clk);
      #1 got = (stored === 1'b1);
    end
  endtask
  function automatic logic [15:0] mk(input int i, input logic t);
    logic [15:0] r;
    r = 16'($urandom);
    r[MORE_PAGES_BIT:COMPLY_BIT] = i[3:0];
    r[TOGGLE_BIT] = t;
    return r;
  endfunction
  //////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(26559));
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    rdx(PARTNER_NP_OFS, 16'h0000);
    rdx(10'h010, 16'h0000);
    rdx(CTRL_OFS, 16'h0001);
    $display("reset test done");
    tog = 1'b1;
    for (int i = 0; i < 16; i++) begin
      w = mk(i, ~tog);
      @(posedge clk);
      pend <= 1'($urandom);
      send(w, 3);
      chk(16'(got), 16'h0001);
      chk(16'(ack), {15'h0000, !pend});
      rdx(PARTNER_NP_OFS, w);
      wrx(PARTNER_NP_OFS, ~w);
      rdx(PARTNER_NP_OFS, w);
      tog = w[TOGGLE_BIT];
    end
    $display("page test done");
    @(posedge clk);
    pend <= 1'b0;
    send(mk(5, ~tog), 2);
    chk(16'({got, ack}), 16'h0000);
    send(mk(9, tog), 3);
    chk(16'({got, terr}), 16'h0001);
    rdx(PARTNER_NP_OFS, w);
    rdx(CTRL_OFS, 16'h0101);
    $display("refusal test done");
    wrx(CTRL_OFS, 16'h0002);
    rdx(CTRL_OFS, 16'h0000);
    send(mk(3, ~tog), 3);
    chk(16'({got, terr}), 16'h0000);
    rdx(PARTNER_NP_OFS, w);
    wrx(CTRL_OFS, 16'h0001);
    $display("control test done");
    @(posedge clk);
    ce <= 1'b0;
    send(mk(7, ~tog), 3);
    chk(16'(got), 16'h0000);
    @(posedge clk);
    ce <= 1'b1;
    w = mk(7, ~tog);
    send(w, 3);
    chk(16'({got, ack}), 16'h0003);
    rdx(PARTNER_NP_OFS, w);
    $display("enable test done");
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    #1 chk(16'({ack, terr, stored}), 16'h0000);
    rdx(PARTNER_NP_OFS, 16'h0000);
    rdx(CTRL_OFS, 16'h0001);
    $display("second reset test done");
    results();
  end
endmodule // partner_next_page_status_bench
